// ==== pkg/fsp_pkg.sv ====
// Purpose: shared constants for the flash security and protection block
// Assumes: apb slave, 32-bit data, one register per aligned word
// Notes:   byte offsets below are local to the block's apb window
package fsp_pkg;
    localparam int          APB_AW        = 12;
    localparam int          KEY_SLOTS     = 8;
    localparam logic [11:0] OFS_SECURITY  = 12'h000;
    localparam logic [11:0] OFS_KEYCFG    = 12'h004;
    localparam logic [11:0] OFS_PROT      = 12'h008;
    localparam int          KEY_WRITE_REDIRECT_BIT_BIT    = 5;
    localparam int          LOCK_BIT      = 7;
    localparam int          SIZE_W        = 7;
    localparam logic [15:0] KEY_BASE      = 16'hFFB0;
    localparam logic [15:0] KEY_LAST      = 16'hFFB7;
    localparam logic [1:0]  SEC_UNSECURED = 2'h2;
    // secure until the stored image has been loaded
    localparam logic [1:0]  SEC_RST       = 2'h3;
    localparam logic [7:0]  PROT_RST      = 8'hFF;
    localparam logic [7:0]  KEYCFG_RST    = 8'h00;
endpackage : fsp_pkg

// ==== pkg/fsp_key_if.sv ====
// Purpose: carries key byte writes to the backdoor key store
// Assumes: one clock domain
// Notes:   slots is the whole key, slot 0 in the low byte
interface fsp_key_if;
    logic        wr;
    logic [2:0]  idx;
    logic [7:0]  data;
    logic        clr;
    logic [63:0] slots;
    modport ctrl  (output wr, output idx, output data, output clr, input slots);
    modport store (input wr, input idx, input data, input clr, output slots);
endinterface : fsp_key_if

// ==== src/fsp_key_slots.sv ====
// Purpose: eight backdoor compare byte slots
// Assumes: writes arrive one byte at a time
// Notes:   cleared after every compare so a stale key cannot be reused
module fsp_key_slots
    import fsp_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    fsp_key_if.store  key
);
    logic [7:0] slot_q [KEY_SLOTS];

    for (genvar g = 0; g < KEY_SLOTS; g++) begin : g_slot
        always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                slot_q[g] <= 8'h00;
            end else if (key.clr) begin
                slot_q[g] <= 8'h00;
            end else if (key.wr && key.idx == 3'(g)) begin
                slot_q[g] <= key.data;
            end
        end
        assign key.slots[8*g +: 8] = slot_q[g];
    end
endmodule : fsp_key_slots

// ==== src/fsp_top.sv ====
// Purpose: flash security state, key redirect and protection register
// Assumes: flash writes, stored images and debug writes are synchronous
// Notes:   stored images load at the first edge after reset release
// Function
// - only code 1:0 unsecured; key/blank unsecure
// - redirect clear: key range write starts command
// - redirect set: key range writes fill slots
// - stored image copied into protection at first edge after reset release
// - protection register readable at any time
// - unlocked: accept only smaller protected size
// - locked: software writes never change protection
// - debug writes bypass protection write limits
//
// Our own choices: the APB interface to the registers and the placing of the registers.
module fsp_top
    import fsp_pkg::*;
(
    input  wire logic                clock_i,
    input  wire logic                rst_n_i,
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [APB_AW-1:0]   paddr_i,
    input  wire logic [31:0]         pwdata_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    input  wire logic                flash_wr_i,
    input  wire logic [15:0]         flash_addr_i,
    input  wire logic [7:0]          flash_wdata_i,
    input  wire logic [7:0]          nv_prot_i,
    input  wire logic [1:0]          nv_sec_i,
    input  wire logic [63:0]         nv_key_i,
    input  wire logic                key_check_i,
    input  wire logic                blank_ok_i,
    input  wire logic                dbg_prot_wr_i,
    input  wire logic [7:0]          dbg_prot_data_i,
    output logic                     cmd_start_o,
    output logic      [15:0]         cmd_addr_o,
    output logic      [7:0]          cmd_data_o,
    output logic      [1:0]          security_state_o,
    output logic                     unsecured_o,
    output logic      [7:0]          prot_o
);
    fsp_key_if key ();

    fsp_key_slots u_slots (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .key     (key.store)
    );

    logic        loaded_q;
    logic [1:0]  sec_q;
    logic [7:0]  keycfg_q;
    logic [7:0]  prot_q;
    logic        ready_q;
    logic [31:0] rdata_q;
    logic        err_q;
    logic        cmd_q;
    logic [15:0] cmd_addr_q;
    logic [7:0]  cmd_data_q;
    logic        unsec_q;

    // bus decode; one wait state so every output stays a flop
    wire         access   = psel_i && penable_i;
    wire         done     = access && ready_q;
    wire         hit_sec  = paddr_i == OFS_SECURITY;
    wire         hit_cfg  = paddr_i == OFS_KEYCFG;
    wire         hit_prot = paddr_i == OFS_PROT;
    wire         mapped   = hit_sec || hit_cfg || hit_prot;
    wire         wr_cfg   = done && pwrite_i && hit_cfg;
    wire         wr_prot  = done && pwrite_i && hit_prot;
    wire         redirect = keycfg_q[KEY_WRITE_REDIRECT_BIT_BIT];
    wire         in_key   = flash_addr_i >= KEY_BASE && flash_addr_i <= KEY_LAST;
    wire         key_wr   = flash_wr_i && in_key && redirect;
    wire         start_wr = flash_wr_i && !key_wr;
    wire         key_ok   = key.slots == nv_key_i;
    wire         prot_lock = prot_q[LOCK_BIT];
    wire [SIZE_W-1:0] new_size = pwdata_i[SIZE_W-1:0];
    wire         shrink   = new_size < prot_q[SIZE_W-1:0];
    wire [31:0]  rd_mux   = hit_sec  ? {30'h0, sec_q} :
                            hit_cfg  ? {24'h0, keycfg_q} :
                            hit_prot ? {24'h0, prot_q} : 32'h0;

    assign key.wr   = key_wr;
    assign key.idx  = flash_addr_i[2:0];
    assign key.data = flash_wdata_i;
    assign key.clr  = key_check_i;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_q <= 1'b0;
            rdata_q <= 32'h0;
            err_q   <= 1'b0;
        end else begin
            ready_q <= access && !ready_q;
            rdata_q <= (access && !ready_q && !pwrite_i) ? rd_mux : 32'h0;
            err_q   <= access && !ready_q && !mapped;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            keycfg_q <= KEYCFG_RST;
        end else if (wr_cfg) begin
            keycfg_q <= {2'h0, pwdata_i[KEY_WRITE_REDIRECT_BIT_BIT], 5'h0};
        end
    end

    // load strap-like images only after release, never in the reset branch
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loaded_q <= 1'b0;
        end else begin
            loaded_q <= 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sec_q <= SEC_RST;
        end else if (!loaded_q) begin
            sec_q <= nv_sec_i;
        end else if (blank_ok_i || (key_check_i && key_ok)) begin
            sec_q <= SEC_UNSECURED;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prot_q <= PROT_RST;
        end else if (!loaded_q) begin
            prot_q <= nv_prot_i;
        end else if (dbg_prot_wr_i) begin
            prot_q <= dbg_prot_data_i;
        end else if (wr_prot && !prot_lock && shrink) begin
            prot_q <= {prot_q[LOCK_BIT], new_size};
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_q      <= 1'b0;
            cmd_addr_q <= 16'h0;
            cmd_data_q <= 8'h00;
            unsec_q    <= 1'b0;
        end else begin
            cmd_q      <= start_wr;
            cmd_addr_q <= start_wr ? flash_addr_i : cmd_addr_q;
            cmd_data_q <= start_wr ? flash_wdata_i : cmd_data_q;
            unsec_q    <= (sec_d_view() == SEC_UNSECURED);
        end
    end

    // mirrors the next security value so the decode flag tracks sec_q exactly
    function automatic logic [1:0] sec_d_view();
        logic [1:0] v;
        v = sec_q;
        if (!loaded_q) begin
            v = nv_sec_i;
        end else if (blank_ok_i || (key_check_i && key_ok)) begin
            v = SEC_UNSECURED;
        end
        return v;
    endfunction : sec_d_view

    assign prdata_o         = rdata_q;
    assign pready_o         = ready_q;
    assign pslverr_o        = err_q;
    assign cmd_start_o      = cmd_q;
    assign cmd_addr_o       = cmd_addr_q;
    assign cmd_data_o       = cmd_data_q;
    assign security_state_o = sec_q;
    assign unsecured_o      = unsec_q;
    assign prot_o           = prot_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    property p_unsec_decode;
        unsecured_o == (security_state_o == SEC_UNSECURED);
    endproperty
    a_unsec_decode: assert property (p_unsec_decode)
        else $error("unsecured flag disagrees with state");

    property p_unlock_event;
        loaded_q && blank_ok_i |=> security_state_o == SEC_UNSECURED;
    endproperty
    a_unlock_event: assert property (p_unlock_event)
        else $error("blank check did not unsecure");

    property p_key_cmd;
        flash_wr_i && in_key && !redirect |=> cmd_start_o && cmd_addr_o == $past(flash_addr_i);
    endproperty
    a_key_cmd: assert property (p_key_cmd)
        else $error("key range write did not start command");

    property p_key_capture;
        key_wr && !key_check_i |=> !cmd_start_o
            && key.slots[8*$past(flash_addr_i[2:0]) +: 8] == $past(flash_wdata_i);
    endproperty
    a_key_capture: assert property (p_key_capture)
        else $error("key byte not captured");

    property p_reset_load;
        $rose(loaded_q) |-> prot_o == $past(nv_prot_i);
    endproperty
    a_reset_load: assert property (p_reset_load)
        else $error("protection image not loaded");

    property p_read_prot;
        access && !ready_q && !pwrite_i && hit_prot
            |=> pready_o && prdata_o == {24'h0, $past(prot_o)};
    endproperty
    a_read_prot: assert property (p_read_prot)
        else $error("protection read wrong");

    property p_increase;
        wr_prot && loaded_q && !dbg_prot_wr_i && !prot_lock && shrink
            |=> prot_o[SIZE_W-1:0] == $past(new_size);
    endproperty
    a_increase: assert property (p_increase)
        else $error("protection increase not accepted");

    property p_lock;
        wr_prot && loaded_q && !dbg_prot_wr_i && prot_lock |=> $stable(prot_o);
    endproperty
    a_lock: assert property (p_lock)
        else $error("locked protection changed");

    property p_debug;
        loaded_q && dbg_prot_wr_i |=> prot_o == $past(dbg_prot_data_i);
    endproperty
    a_debug: assert property (p_debug)
        else $error("debug write not applied");

    property p_reject;
        wr_prot && loaded_q && !dbg_prot_wr_i && !shrink |=> $stable(prot_o);
    endproperty
    a_reject: assert property (p_reject)
        else $error("protection decrease accepted");

    c_key_unlock: cover property (key_check_i && key_ok && loaded_q);
    c_cmd_start:  cover property (cmd_start_o);
    c_prot_wr:    cover property (wr_prot && !prot_lock && shrink);
    c_err:        cover property (pslverr_o);
endmodule : fsp_top

// ==== tb/fsp_top_bench.sv ====
// Purpose: self-checking bench for the flash security and protection block
// Assumes: apb slave with one wait state, flash and debug events as one-cycle pulses
// Notes:   expected values come from the package constants and the stimulus only
module fsp_top_bench
    import fsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clock_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic              psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [APB_AW-1:0] paddr_i = '0;
    logic [31:0]       pwdata_i = '0, prdata_o, rdv;
    logic              pready_o, pslverr_o, errv;
    logic              flash_wr_i = 1'b0, key_check_i = 1'b0, blank_ok_i = 1'b0;
    logic [15:0]       flash_addr_i = '0, cmd_addr_o;
    logic [7:0]        flash_wdata_i = '0, nv_prot_i = 8'h3C, dbg_prot_data_i = '0;
    logic [1:0]        nv_sec_i = 2'h3, security_state_o;
    logic [63:0]       nv_key_i = 64'h8877665544332211;
    logic              dbg_prot_wr_i = 1'b0, cmd_start_o, unsecured_o;
    logic [7:0]        cmd_data_o, prot_o;
    int                bad_count = 0, total_checks = 0;

    always #5 clock_i = ~clock_i;

    fsp_top i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .flash_wr_i(flash_wr_i), .flash_addr_i(flash_addr_i), .flash_wdata_i(flash_wdata_i),
        .nv_prot_i(nv_prot_i), .nv_sec_i(nv_sec_i), .nv_key_i(nv_key_i),
        .key_check_i(key_check_i), .blank_ok_i(blank_ok_i), .dbg_prot_wr_i(dbg_prot_wr_i),
        .dbg_prot_data_i(dbg_prot_data_i), .cmd_start_o(cmd_start_o), .cmd_addr_o(cmd_addr_o),
        .cmd_data_o(cmd_data_o), .security_state_o(security_state_o),
        .unsecured_o(unsecured_o), .prot_o(prot_o));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // request held until pready is sampled high or 50 edges pass, released at that edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= wd;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        rdv = prdata_o;
        errv = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        chk("apb_answered", 32'h1, {31'h0, pready_o});
        // the write lands at this edge; let it settle before callers look
        #1;
    endtask : apb

    task automatic fwr(input logic [15:0] a, input logic [7:0] d, input logic exp);
        @(posedge clock_i);
        flash_wr_i <= 1'b1; flash_addr_i <= a; flash_wdata_i <= d;
        @(posedge clock_i);
        flash_wr_i <= 1'b0;
        #1 chk("cmd_start", {31'h0, exp}, {31'h0, cmd_start_o});
    endtask : fwr

    task automatic do_reset;
        rst_n_i <= 1'b0;
        repeat (8) @(posedge clock_i);
        chk("prot_in_reset", 32'hFF, {24'h0, prot_o});
        chk("sec_in_reset", 32'h3, {30'h0, security_state_o});
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        #1;
    endtask : do_reset

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    // about 130 cycles expected; cut off far beyond
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end

    initial begin
        do_reset();
        chk("prot_loaded", 32'h3C, {24'h0, prot_o});
        chk("unsecured", 32'h0, {31'h0, unsecured_o});
        apb(1'b0, OFS_PROT, '0);
        chk("prot_read", 32'h3C, rdv);
        apb(1'b0, 12'hFFC, '0);
        chk("unmapped_err", 32'h1, {31'h0, errv});
        chk("unmapped_data", 32'h0, rdv);
        $display("test reset_load done");
        apb(1'b1, OFS_PROT, 32'h50);
        chk("prot_larger", 32'h3C, {24'h0, prot_o});
        apb(1'b1, OFS_PROT, 32'h3C);
        chk("prot_equal", 32'h3C, {24'h0, prot_o});
        apb(1'b1, OFS_PROT, 32'h20);
        chk("prot_smaller", 32'h20, {24'h0, prot_o});
        $display("test unlocked_writes done");
        fwr(16'hFFB3, 8'hA5, 1'b1);
        chk("cmd_addr", 32'hFFB3, {16'h0, cmd_addr_o});
        chk("cmd_data", 32'hA5, {24'h0, cmd_data_o});
        apb(1'b1, OFS_KEYCFG, 32'h20);
        apb(1'b0, OFS_KEYCFG, '0);
        chk("keycfg_read", 32'h20, rdv);
        for (int i = 0; i < KEY_SLOTS; i++) begin
            fwr(KEY_BASE + 16'(i), nv_key_i[8*i +: 8], 1'b0);
        end
        fwr(16'hFFB8, 8'h11, 1'b1);
        @(posedge clock_i) key_check_i <= 1'b1;
        @(posedge clock_i) key_check_i <= 1'b0;
        #1 chk("sec_after_key", 32'h2, {30'h0, security_state_o});
        chk("unsecured_key", 32'h1, {31'h0, unsecured_o});
        apb(1'b0, OFS_SECURITY, '0);
        chk("sec_read", 32'h2, rdv);
        $display("test key_redirect done");
        @(posedge clock_i) dbg_prot_wr_i <= 1'b1;
        dbg_prot_data_i <= 8'h85;
        @(posedge clock_i) dbg_prot_wr_i <= 1'b0;
        #1 chk("prot_debug", 32'h85, {24'h0, prot_o});
        apb(1'b1, OFS_PROT, 32'h01);
        chk("prot_locked", 32'h85, {24'h0, prot_o});
        apb(1'b0, OFS_PROT, '0);
        chk("prot_read_locked", 32'h85, rdv);
        $display("test debug_lock done");
        // every stored code, then a blank check must unsecure it
        for (int c = 0; c < 4; c++) begin
            nv_sec_i = 2'(c);
            do_reset();
            chk("sec_code", 32'(c), {30'h0, security_state_o});
            chk("unsec_code", {31'h0, c == 2}, {31'h0, unsecured_o});
            @(posedge clock_i) blank_ok_i <= 1'b1;
            @(posedge clock_i) blank_ok_i <= 1'b0;
            #1 chk("sec_blank", 32'h2, {30'h0, security_state_o});
        end
        $display("test security_codes done");
        end_sim();
    end
endmodule : fsp_top_bench
